// [src/usd_regs.svh]
// Register map, field positions, reset values and sizes of the shadow data port
`ifndef USD_REGS_SVH
`define USD_REGS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define USD_ALIAS_BASE 32'h5000_1130
`define USD_ALIAS_ONE 32'h5000_1134
`define USD_ALIAS_TWO 32'h5000_1138
`define USD_ALIAS_SPAN 32'h0000_0040
`define USD_CTRL_ADDR 32'h5000_1100
`define USD_STAT_ADDR 32'h5000_1104

// ****************************************************************
// Fields
// ****************************************************************
`define USD_CTRL_FIFO_EN 0
`define USD_CTRL_IR_MODE 1
`define USD_STAT_DR 0
`define USD_STAT_OVR 1
`define USD_STAT_RX_FULL 2
`define USD_STAT_TX_FULL 3
`define USD_STAT_TX_HOLDING_EMPTY_FLAG 5

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define USD_CTRL_RST 2'h0
`define USD_FIFO_DEPTH 5'h10
`define USD_RESP_OKAY 2'h0
`define USD_RESP_SLVERR 2'h2

`endif

// [src/usd_pkg.sv]
// Types shared by the shadow data port
package usd_pkg;
`include "usd_regs.svh"

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [31:0] aw_addr;
      logic [7:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic fifo_en;
      logic ir_mode;
      logic overrun;
      logic [15:0][7:0] rx_mem;
      logic [3:0] rx_wptr;
      logic [3:0] rx_rptr;
      logic [4:0] rx_cnt;
      logic [15:0][7:0] tx_mem;
      logic [3:0] tx_wptr;
      logic [3:0] tx_rptr;
      logic [4:0] tx_cnt;
      logic [7:0] tx_data;
      logic tx_ser_req;
      logic tx_ir_req;
      logic data_ready;
      logic hold_empty;
   } usd_state_t;

endpackage

// [src/usd_shadow_data.sv]
// Shadow receive/transmit data port with AXI4-Lite slave and character FIFOs
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
// Operation
// - Sixteen aliased words reach the data port.
// - Read returns serial or infrared received character.
// - No FIFO: new character overwrites, flags overrun.
// - FIFO on: read returns receive FIFO head.
// - Full receive FIFO with no read in the same edge drops arrival, flags overrun.
// - Write sends character on serial or infrared.
// - No FIFO: a write made while line output is busy clears holding empty.
// - No FIFO: later writes replace held character.
// - FIFO on: sixteen writes fill transmit FIFO while line output is busy.
// - Write to full transmit FIFO is dropped.
module usd_shadow_data
   import usd_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [31:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [31:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic SER_RX_VALID_I,
   input wire logic [7:0] SER_RX_DATA_I,
   input wire logic IR_RX_VALID_I,
   input wire logic [7:0] IR_RX_DATA_I,
   output logic [7:0] TX_DATA_O,
   output logic TX_SER_REQ_O,
   output logic TX_IR_REQ_O,
   input wire logic TX_TAKE_I,
   output logic RX_DATA_READY_O,
   output logic TX_HOLD_EMPTY_O
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic is_alias(input logic [31:0] addr);
      logic [31:0] off;
      off = addr - `USD_ALIAS_BASE;
      return (off < `USD_ALIAS_SPAN) && (off[1:0] == 2'h0);
   endfunction

   function automatic logic [3:0] ptr_inc(input logic [3:0] p);
      return p + 4'h1;
   endfunction

   function automatic logic is_ctrl(input logic [31:0] addr);
      return addr == `USD_CTRL_ADDR;
   endfunction

   function automatic logic is_stat(input logic [31:0] addr);
      return addr == `USD_STAT_ADDR;
   endfunction

   // Unmapped words answer with an error and change nothing
   function automatic logic is_mapped(input logic [31:0] addr);
      return is_alias(addr) || is_ctrl(addr) || is_stat(addr);
   endfunction

   function automatic logic is_full(input logic [4:0] cnt);
      return cnt == `USD_FIFO_DEPTH;
   endfunction

   function automatic logic [31:0] ctrl_word(input usd_state_t s);
      logic [31:0] w;
      w = 32'h0;
      w[`USD_CTRL_FIFO_EN] = s.fifo_en;
      w[`USD_CTRL_IR_MODE] = s.ir_mode;
      return w;
   endfunction

   function automatic logic [31:0] stat_word(input usd_state_t s);
      logic [31:0] w;
      w = 32'h0;
      w[`USD_STAT_DR] = s.rx_cnt != 5'h0;
      w[`USD_STAT_OVR] = s.overrun;
      w[`USD_STAT_RX_FULL] = is_full(s.rx_cnt);
      w[`USD_STAT_TX_FULL] = is_full(s.tx_cnt);
      w[`USD_STAT_TX_HOLDING_EMPTY_FLAG] = s.tx_cnt == 5'h0;
      return w;
   endfunction

   // Push and pop in one edge leave the count alone
   function automatic logic [4:0] cnt_next(input logic [4:0] cnt,
                                           input logic push,
                                           input logic pop);
      logic [4:0] n;
      n = cnt;
      if (push && !pop) begin
         n = cnt + 5'h1;
      end else if (pop && !push) begin
         n = cnt - 5'h1;
      end
      return n;
   endfunction

   usd_state_t state_ff;
   usd_state_t nxt_state;

   logic ar_hs;
   logic aw_hs;
   logic w_hs;
   logic wr_go;
   logic rx_push;
   logic [7:0] rx_in;
   logic rx_pop;
   logic tx_wr;
   logic tx_drain;
   logic [7:0] rx_head;
   logic rx_keep;
   logic tx_keep;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;
      ar_hs = ARVALID_I && state_ff.arready;
      aw_hs = AWVALID_I && state_ff.awready;
      w_hs = WVALID_I && state_ff.wready;
      wr_go = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;
      rx_head = state_ff.fifo_en ? state_ff.rx_mem[state_ff.rx_rptr]
                                 : state_ff.rx_mem[0];
      // Mode picks which receiver feeds the buffer
      rx_push = state_ff.ir_mode ? IR_RX_VALID_I : SER_RX_VALID_I;
      rx_in = state_ff.ir_mode ? IR_RX_DATA_I : SER_RX_DATA_I;
      rx_pop = ar_hs && is_alias(ARADDR_I) && (state_ff.rx_cnt != 5'h0);
      tx_wr = wr_go && is_alias(state_ff.aw_addr) && state_ff.w_strb0;
      tx_drain = !state_ff.tx_ser_req && !state_ff.tx_ir_req &&
                 (state_ff.tx_cnt != 5'h0);
      // A read in the same edge frees a slot in time
      rx_keep = rx_push && (!is_full(state_ff.rx_cnt) || rx_pop);
      // Drain frees a slot only next edge; keeps full honest
      tx_keep = tx_wr && !is_full(state_ff.tx_cnt);

      // Write address and data channels, taken in either order
      if (aw_hs) begin
         nxt_state.aw_held = 1'b1;
         nxt_state.awready = 1'b0;
         nxt_state.aw_addr = AWADDR_I;
      end
      if (w_hs) begin
         nxt_state.w_held = 1'b1;
         nxt_state.wready = 1'b0;
         nxt_state.w_data = WDATA_I[7:0];
         nxt_state.w_strb0 = WSTRB_I[0];
      end
      if (wr_go) begin
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp = `USD_RESP_OKAY;
         if (!is_mapped(state_ff.aw_addr)) begin
            nxt_state.bresp = `USD_RESP_SLVERR;
         end
      end
      if (state_ff.bvalid && BREADY_I) begin
         nxt_state.bvalid = 1'b0;
         nxt_state.aw_held = 1'b0;
         nxt_state.w_held = 1'b0;
         nxt_state.awready = 1'b1;
         nxt_state.wready = 1'b1;
      end

      // Read channel; data is captured at the address edge
      if (ar_hs) begin
         nxt_state.arready = 1'b0;
         nxt_state.rvalid = 1'b1;
         nxt_state.rresp = `USD_RESP_OKAY;
         nxt_state.rdata = 32'h0;
         if (is_alias(ARADDR_I)) begin
            nxt_state.rdata = {24'h0, rx_head};
         end else if (is_ctrl(ARADDR_I)) begin
            nxt_state.rdata = ctrl_word(state_ff);
         end else if (is_stat(ARADDR_I)) begin
            nxt_state.rdata = stat_word(state_ff);
            // Reading status clears overrun; a new one below still wins
            nxt_state.overrun = 1'b0;
         end else begin
            nxt_state.rresp = `USD_RESP_SLVERR;
         end
      end
      if (state_ff.rvalid && RREADY_I) begin
         nxt_state.rvalid = 1'b0;
         nxt_state.arready = 1'b1;
      end

      // Receive buffer
      if (state_ff.fifo_en) begin
         if (rx_pop) begin
            nxt_state.rx_rptr = ptr_inc(state_ff.rx_rptr);
         end
         if (rx_push) begin
            // Full and no read: arrival is lost, contents kept
            if (!rx_keep) begin
               nxt_state.overrun = 1'b1;
            end else begin
               nxt_state.rx_mem[state_ff.rx_wptr] = rx_in;
               nxt_state.rx_wptr = ptr_inc(state_ff.rx_wptr);
            end
         end
         nxt_state.rx_cnt = cnt_next(state_ff.rx_cnt, rx_keep,
                                     rx_pop);
      end else begin
         if (rx_push) begin
            nxt_state.rx_mem[0] = rx_in;
            nxt_state.rx_cnt = 5'h1;
            if (state_ff.rx_cnt != 5'h0 && !rx_pop) begin
               nxt_state.overrun = 1'b1;
            end
         end else if (rx_pop) begin
            nxt_state.rx_cnt = 5'h0;
         end
      end

      // Transmit side: line takes the head when its output is free
      if (state_ff.tx_ser_req && TX_TAKE_I) begin
         nxt_state.tx_ser_req = 1'b0;
      end
      if (state_ff.tx_ir_req && TX_TAKE_I) begin
         nxt_state.tx_ir_req = 1'b0;
      end
      if (tx_drain) begin
         nxt_state.tx_data = state_ff.fifo_en ?
                             state_ff.tx_mem[state_ff.tx_rptr] :
                             state_ff.tx_mem[0];
         nxt_state.tx_ser_req = !state_ff.ir_mode;
         nxt_state.tx_ir_req = state_ff.ir_mode;
      end
      if (state_ff.fifo_en) begin
         if (tx_drain) begin
            nxt_state.tx_rptr = ptr_inc(state_ff.tx_rptr);
         end
         // Write to a full FIFO is dropped here
         if (tx_keep) begin
            nxt_state.tx_mem[state_ff.tx_wptr] = state_ff.w_data;
            nxt_state.tx_wptr = ptr_inc(state_ff.tx_wptr);
         end
         nxt_state.tx_cnt = cnt_next(state_ff.tx_cnt, tx_keep,
                                     tx_drain);
      end else begin
         if (tx_wr) begin
            nxt_state.tx_mem[0] = state_ff.w_data;
            nxt_state.tx_cnt = 5'h1;
         end else if (tx_drain) begin
            nxt_state.tx_cnt = 5'h0;
         end
      end

      // Control write; a change of FIFO mode flushes both buffers
      if (wr_go && is_ctrl(state_ff.aw_addr) && state_ff.w_strb0) begin
         nxt_state.fifo_en = state_ff.w_data[`USD_CTRL_FIFO_EN];
         nxt_state.ir_mode = state_ff.w_data[`USD_CTRL_IR_MODE];
         if (state_ff.w_data[`USD_CTRL_FIFO_EN] != state_ff.fifo_en) begin
            nxt_state.rx_wptr = 4'h0;
            nxt_state.rx_rptr = 4'h0;
            nxt_state.rx_cnt = 5'h0;
            nxt_state.tx_wptr = 4'h0;
            nxt_state.tx_rptr = 4'h0;
            nxt_state.tx_cnt = 5'h0;
         end
      end

      nxt_state.data_ready = nxt_state.rx_cnt != 5'h0;
      nxt_state.hold_empty = nxt_state.tx_cnt == 5'h0;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         // Idle bus, empty buffers, both modes off
         state_ff.awready <= 1'b1;
         state_ff.wready <= 1'b1;
         state_ff.aw_held <= 1'b0;
         state_ff.w_held <= 1'b0;
         state_ff.aw_addr <= 32'h0;
         state_ff.w_data <= 8'h0;
         state_ff.w_strb0 <= 1'b0;
         state_ff.bvalid <= 1'b0;
         state_ff.bresp <= `USD_RESP_OKAY;
         state_ff.arready <= 1'b1;
         state_ff.rvalid <= 1'b0;
         state_ff.rdata <= 32'h0;
         state_ff.rresp <= `USD_RESP_OKAY;
         state_ff.fifo_en <= 1'(`USD_CTRL_RST >> `USD_CTRL_FIFO_EN);
         state_ff.ir_mode <= 1'(`USD_CTRL_RST >> `USD_CTRL_IR_MODE);
         state_ff.overrun <= 1'b0;
         state_ff.rx_mem <= '0;
         state_ff.rx_wptr <= 4'h0;
         state_ff.rx_rptr <= 4'h0;
         state_ff.rx_cnt <= 5'h0;
         state_ff.tx_mem <= '0;
         state_ff.tx_wptr <= 4'h0;
         state_ff.tx_rptr <= 4'h0;
         state_ff.tx_cnt <= 5'h0;
         state_ff.tx_data <= 8'h0;
         state_ff.tx_ser_req <= 1'b0;
         state_ff.tx_ir_req <= 1'b0;
         state_ff.data_ready <= 1'b0;
         state_ff.hold_empty <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign AWREADY_O = state_ff.awready;
   assign WREADY_O = state_ff.wready;
   assign BRESP_O = state_ff.bresp;
   assign BVALID_O = state_ff.bvalid;
   assign ARREADY_O = state_ff.arready;
   assign RDATA_O = state_ff.rdata;
   assign RRESP_O = state_ff.rresp;
   assign RVALID_O = state_ff.rvalid;
   assign TX_DATA_O = state_ff.tx_data;
   assign TX_SER_REQ_O = state_ff.tx_ser_req;
   assign TX_IR_REQ_O = state_ff.tx_ir_req;
   assign RX_DATA_READY_O = state_ff.data_ready;
   assign TX_HOLD_EMPTY_O = state_ff.hold_empty;

endmodule // usd_shadow_data

// [verification/usd_shadow_data_props.sv]
// Concurrent checks on the shadow data port pins
`timescale 1ns/1ps
module usd_shadow_data_props (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic AWVALID_I,
   input wire logic AWREADY_O,
   input wire logic WVALID_I,
   input wire logic WREADY_O,
   input wire logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic ARVALID_I,
   input wire logic ARREADY_O,
   input wire logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic [31:0] RDATA_O,
   input wire logic [7:0] TX_DATA_O,
   input wire logic TX_SER_REQ_O,
   input wire logic TX_IR_REQ_O,
   input wire logic TX_TAKE_I,
   input wire logic SER_RX_VALID_I,
   input wire logic IR_RX_VALID_I
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence wr_taken_s;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence
   sequence wr_answer_s;
      !AWREADY_O && !WREADY_O ##1 BVALID_O;
   endsequence
   wr_answer_a: assert property (wr_taken_s |=> wr_answer_s)
      else $error("write answer wrong");
   rd_answer_a: assert property (
      ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
      else $error("read answer wrong");
   b_stands_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
      else $error("write response dropped");
   r_stands_a: assert property (
      RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data not held");
   upper_zero_a: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h000000)
      else $error("upper bytes not zero");
   tx_stands_a: assert property (
      TX_SER_REQ_O && !TX_TAKE_I |=> TX_SER_REQ_O && $stable(TX_DATA_O))
      else $error("transmit request not held");
   tx_release_a: assert property (
      (TX_SER_REQ_O || TX_IR_REQ_O) && TX_TAKE_I
      |=> !TX_SER_REQ_O && !TX_IR_REQ_O)
      else $error("transmit request not released");
   tx_one_path_a: assert property (!(TX_SER_REQ_O && TX_IR_REQ_O))
      else $error("both transmit paths requested");
endmodule // usd_shadow_data_props

// [verification/usd_line_peer.sv]
// Line peer model: sends received characters, takes transmit characters
`timescale 1ns/1ps
module usd_line_peer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_ser_req_i,
   input wire logic tx_ir_req_i,
   output logic ser_valid_o,
   output logic [7:0] ser_data_o,
   output logic ir_valid_o,
   output logic [7:0] ir_data_o,
   output logic tx_take_o
);
   logic stall = 1'b0;
   logic last_ir = 1'b0;
   logic [7:0] last = 8'h00;
   int cnt = 0;
   initial begin
      ser_valid_o = 1'b0;
      ir_valid_o = 1'b0;
      ser_data_o = 8'h00;
      ir_data_o = 8'h00;
      tx_take_o = 1'b0;
   end
   // One-cycle character pulse; lines show junk when idle
   task automatic send(input logic ir, input logic [7:0] ch);
      @(posedge clk_i);
      ir_valid_o <= ir;
      ser_valid_o <= !ir;
      ir_data_o <= ch;
      ser_data_o <= ch;
      @(posedge clk_i);
      ir_valid_o <= 1'b0;
      ser_valid_o <= 1'b0;
      ir_data_o <= ~ch;
      ser_data_o <= ~ch;
   endtask
   // Mid-cycle change keeps clear of the take logic's edge
   task automatic set_stall(input logic v);
      @(negedge clk_i);
      stall = v;
   endtask
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_take_o <= 1'b0;
      end else if ((tx_ser_req_i || tx_ir_req_i) && !tx_take_o && !stall) begin
         tx_take_o <= 1'b1;
         cnt <= cnt + 1;
         last <= tx_data_i;
         last_ir <= tx_ir_req_i;
      end else begin
         tx_take_o <= 1'b0;
      end
   end
endmodule // usd_line_peer

// [verification/usd_shadow_data_test.sv]
// Self-checking bench for the shadow data port
`timescale 1ns/1ps
`include "usd_regs.svh"
module usd_shadow_data_test;
   logic CLK_I = 1'b0, RST_N_I = 1'b0, AWVALID_I = 1'b0, WVALID_I = 1'b0;
   logic BREADY_I = 1'b0, ARVALID_I = 1'b0, RREADY_I = 1'b0;
   logic [31:0] AWADDR_I = 32'h0, WDATA_I = 32'h0, ARADDR_I = 32'h0;
   logic [3:0] WSTRB_I = 4'hf;
   logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, TX_SER_REQ_O;
   logic TX_IR_REQ_O, RX_DATA_READY_O, TX_HOLD_EMPTY_O, TX_TAKE_I;
   logic SER_RX_VALID_I, IR_RX_VALID_I;
   logic [7:0] SER_RX_DATA_I, IR_RX_DATA_I, TX_DATA_O;
   logic [1:0] BRESP_O, RRESP_O, rsp;
   logic [31:0] RDATA_O, rd_d;
   int fail_count = 0, cmp_count = 0, c;
   always #25 CLK_I = ~CLK_I;
   usd_shadow_data usd_shadow_data_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
      .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
      .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
      .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
      .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I),
      .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
      .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
      .SER_RX_VALID_I(SER_RX_VALID_I), .SER_RX_DATA_I(SER_RX_DATA_I),
      .IR_RX_VALID_I(IR_RX_VALID_I), .IR_RX_DATA_I(IR_RX_DATA_I),
      .TX_DATA_O(TX_DATA_O), .TX_SER_REQ_O(TX_SER_REQ_O),
      .TX_IR_REQ_O(TX_IR_REQ_O), .TX_TAKE_I(TX_TAKE_I),
      .RX_DATA_READY_O(RX_DATA_READY_O), .TX_HOLD_EMPTY_O(TX_HOLD_EMPTY_O));
   usd_line_peer usd_line_peer_inst (.clk_i(CLK_I), .rst_n_i(RST_N_I),
      .tx_data_i(TX_DATA_O), .tx_ser_req_i(TX_SER_REQ_O),
      .tx_ir_req_i(TX_IR_REQ_O), .ser_valid_o(SER_RX_VALID_I),
      .ser_data_o(SER_RX_DATA_I), .ir_valid_o(IR_RX_VALID_I),
      .ir_data_o(IR_RX_DATA_I), .tx_take_o(TX_TAKE_I));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Junk in the upper bits must not reach the character
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic ha, hw, hb;
      @(posedge CLK_I);
      {AWADDR_I, WDATA_I} <= {a, 24'hffffff, d};
      {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
      hb = 1'b0;
      while (!hb) begin
         @(negedge CLK_I);
         {ha, hw, hb, rsp} = {AWVALID_I & AWREADY_O,
                              WVALID_I & WREADY_O, BVALID_O, BRESP_O};
         @(posedge CLK_I);
         if (ha) AWVALID_I <= 1'b0;
         if (hw) WVALID_I <= 1'b0;
         if (hb) BREADY_I <= 1'b0;
      end
   endtask
   task automatic rd(input logic [31:0] a);
      logic ha, hr;
      @(posedge CLK_I);
      ARADDR_I <= a;
      {ARVALID_I, RREADY_I} <= 2'h3;
      hr = 1'b0;
      while (!hr) begin
         @(negedge CLK_I);
         {ha, hr, rd_d, rsp} = {ARVALID_I & ARREADY_O, RVALID_O,
                                RDATA_O, RRESP_O};
         @(posedge CLK_I);
         if (ha) ARVALID_I <= 1'b0;
         if (hr) RREADY_I <= 1'b0;
      end
   endtask
   task automatic t_rx_plain();
      chk(RX_DATA_READY_O, 1'b0);
      usd_line_peer_inst.send(1'b0, 8'h3c);
      usd_line_peer_inst.send(1'b0, 8'ha5);
      @(negedge CLK_I);
      chk(RX_DATA_READY_O, 1'b1);
      rd(`USD_ALIAS_TWO);
      chk(rd_d, 32'ha5);
      rd(`USD_STAT_ADDR);
      chk(rd_d[`USD_STAT_OVR], 1'b1);
   endtask
   task automatic t_ir();
      wr(`USD_CTRL_ADDR, 8'h02);
      usd_line_peer_inst.send(1'b1, 8'h6e);
      usd_line_peer_inst.send(1'b0, 8'h11);
      rd(`USD_ALIAS_ONE);
      chk(rd_d, 32'h6e);
      c = usd_line_peer_inst.cnt;
      wr(`USD_ALIAS_ONE, 8'h5a);
      wait (usd_line_peer_inst.cnt == c + 1);
      chk({usd_line_peer_inst.last_ir, usd_line_peer_inst.last}, 9'h15a);
      wr(`USD_CTRL_ADDR, 8'h00);
   endtask
   task automatic t_rx_fifo();
      wr(`USD_CTRL_ADDR, 8'h01);
      for (int i = 0; i < 17; i++) usd_line_peer_inst.send(1'b0, 8'h40 + i[7:0]);
      rd(`USD_STAT_ADDR);
      chk(rd_d[`USD_STAT_OVR], 1'b1);
      for (int i = 0; i < 16; i++) begin
         rd(`USD_ALIAS_BASE + 32'(4 * i));
         chk(rd_d, 32'h40 + 32'(i));
      end
      chk(RX_DATA_READY_O, 1'b0);
   endtask
   task automatic t_tx_plain();
      wr(`USD_CTRL_ADDR, 8'h00);
      usd_line_peer_inst.set_stall(1'b1);
      c = usd_line_peer_inst.cnt;
      wr(`USD_ALIAS_ONE, 8'h81);
      @(negedge CLK_I);
      chk({TX_SER_REQ_O, TX_DATA_O, TX_HOLD_EMPTY_O}, 10'h303);
      wr(`USD_ALIAS_ONE, 8'h82);
      @(negedge CLK_I);
      chk(TX_HOLD_EMPTY_O, 1'b0);
      wr(`USD_ALIAS_TWO, 8'h83);
      usd_line_peer_inst.set_stall(1'b0);
      wait (usd_line_peer_inst.cnt == c + 2);
      chk(usd_line_peer_inst.last, 8'h83);
   endtask
   task automatic t_tx_fifo();
      wr(`USD_CTRL_ADDR, 8'h01);
      usd_line_peer_inst.set_stall(1'b1);
      c = usd_line_peer_inst.cnt;
      for (int i = 0; i < 17; i++) wr(`USD_ALIAS_ONE, 8'h90 + i[7:0]);
      rd(`USD_STAT_ADDR);
      chk(rd_d[`USD_STAT_TX_FULL], 1'b1);
      wr(`USD_ALIAS_ONE, 8'hee);
      usd_line_peer_inst.set_stall(1'b0);
      wait (usd_line_peer_inst.cnt == c + 17);
      @(negedge CLK_I);
      chk({usd_line_peer_inst.last, TX_HOLD_EMPTY_O}, 9'h141);
   endtask
   task automatic t_unmapped();
      wr(32'h5000_1200, 8'h00);
      chk(rsp, `USD_RESP_SLVERR);
      rd(32'h5000_1200);
      chk({rsp, rd_d}, {`USD_RESP_SLVERR, 32'h0});
   endtask
   task automatic report_and_stop();
      $display("Mismatches %0d, compares %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      t_rx_plain();
      t_ir();
      t_rx_fifo();
      t_tx_plain();
      t_tx_fifo();
      t_unmapped();
      report_and_stop();
   end
   // Whole run needs well under this many cycles
   initial begin
      repeat (20000) @(posedge CLK_I);
      fail_count++;
      report_and_stop();
   end
endmodule // usd_shadow_data_test
bind usd_shadow_data usd_shadow_data_props usd_shadow_data_props_inst (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .AWVALID_I(AWVALID_I),
   .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
   .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
   .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
   .RDATA_O(RDATA_O), .TX_DATA_O(TX_DATA_O), .TX_SER_REQ_O(TX_SER_REQ_O),
   .TX_IR_REQ_O(TX_IR_REQ_O), .TX_TAKE_I(TX_TAKE_I),
   .SER_RX_VALID_I(SER_RX_VALID_I), .IR_RX_VALID_I(IR_RX_VALID_I));
